//--- pkg/ctr_pkg.sv
/*
  Constants, register offsets and field layouts for the compact timer.
  Assumes an 8-bit register port with a 3-bit word address.
*/
package ctr_pkg;
  localparam int unsigned CTR_AW = 3;
  localparam int unsigned CTR_DW = 8;
  localparam int unsigned CTR_CW = 10;
  // Register offsets
  localparam logic [2:0] CTR_OFF_CTL_A = 3'h0;
  localparam logic [2:0] CTR_OFF_CTL_B = 3'h1;
  localparam logic [2:0] CTR_OFF_CNT_LO = 3'h2;
  localparam logic [2:0] CTR_OFF_CNT_HI = 3'h3;
  localparam logic [2:0] CTR_OFF_CMPA_LO = 3'h4;
  localparam logic [2:0] CTR_OFF_CMPA_HI = 3'h5;
  localparam logic [2:0] CTR_OFF_STAT = 3'h6;
  localparam logic [2:0] CTR_OFF_MASK = 3'h7;
  // Reset values
  localparam logic [7:0] CTR_RST_BYTE = 8'h00;
  localparam logic [9:0] CTR_RST_CNT = 10'h000;
  localparam logic [2:0] CTR_RST_EV = 3'h0;
  localparam logic [6:0] CTR_RST_PRESC = 7'h00;
  // Counter layout
  localparam logic [9:0] CTR_CNT_MAX = 10'h3FF;
  localparam logic [9:0] CTR_CNT_ONE = 10'h001;
  localparam logic [2:0] CTR_PERIOD_FULL = 3'h0;
  localparam logic [6:0] CTR_P_LOW_ZERO = 7'h00;
  localparam logic [6:0] CTR_PRESC_ALL = 7'h7F;
  localparam logic [6:0] CTR_PRESC_ONE = 7'h01;
  localparam logic [5:0] CTR_HI_PAD = 6'h00;
  // Clock source code for the external pin; lower codes divide the core clock
  localparam logic [2:0] CTR_CLK_SEL_EXT = 3'h7;
  // Operating modes
  localparam logic [1:0] CTR_MODE_CMP = 2'h0;
  localparam logic [1:0] CTR_MODE_PWM = 2'h2;
  localparam logic [1:0] CTR_MODE_TMR = 2'h3;
  // Output functions, compare mode
  localparam logic [1:0] CTR_OFN_HOLD = 2'h0;
  localparam logic [1:0] CTR_OFN_LOW = 2'h1;
  localparam logic [1:0] CTR_OFN_HIGH = 2'h2;
  localparam logic [1:0] CTR_OFN_TOGGLE = 2'h3;
  // Output functions, PWM mode
  localparam logic [1:0] CTR_PFN_INACTIVE = 2'h0;
  localparam logic [1:0] CTR_PFN_ACTIVE = 2'h1;
  localparam logic [1:0] CTR_PFN_PWM = 2'h2;
  // Event bits in status and mask
  localparam int unsigned CTR_EV_P = 0;
  localparam int unsigned CTR_EV_A = 1;
  localparam int unsigned CTR_EV_OVF = 2;

  typedef struct packed {
    logic pause_ctl;
    logic [2:0] clock_source_select;
    logic module_on;
    logic [2:0] period_select;
  } ctr_ctl_a_t;

  typedef struct packed {
    logic [1:0] operating_mode_select;
    logic [1:0] output_function_select;
    logic output_initial_level;
    logic output_polarity;
    logic duty_period_swap;
    logic clear_select;
  } ctr_ctl_b_t;
endpackage

//--- src/ctr_timer.sv
/*
  Compact 10-bit timer with compare A, 3-bit period compare, output pin,
  byte register port and masked interrupt.
  Assumes a single 100 MHz core clock and a register master that issues
  one-cycle strobes and reads data the cycle after a read strobe.
*/
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module ctr_timer
  import ctr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  input wire logic i_ext_clk,
  output logic o_tp
);

  ////////////////////////////////////////////////////////////////////////////
  ctr_ctl_a_t ctl_a_r;
  ctr_ctl_b_t ctl_b_r;
  logic [9:0] cnt_r;
  logic [9:0] cmpa_r;
  logic [7:0] buf_r;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [2:0] mask_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic lvl_r;
  logic tp_r;
  logic on_q_r;
  logic [6:0] presc_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic [6:0] sel_mask;
  logic tick;
  logic run_tick;
  logic on_rise;
  logic [9:0] cnt_inc;
  logic p_hit;
  logic a_hit;
  logic ovf;
  logic clr_any;
  logic [2:0] ev;
  logic [7:0] cnt_lo_w;
  logic [1:0] cnt_hi_w;
  logic [1:0] wdata_lo2_w;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_a_r <= CTR_RST_BYTE;
      ctl_b_r <= CTR_RST_BYTE;
      mask_r <= CTR_RST_EV;
    end else if (i_wr) begin
      case (i_addr)
        CTR_OFF_CTL_A: ctl_a_r <= i_wdata;
        CTR_OFF_CTL_B: ctl_b_r <= i_wdata;
        CTR_OFF_MASK: mask_r <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmpa_r <= CTR_RST_CNT;
    end else if (i_wr && i_addr == CTR_OFF_CMPA_HI) begin
      cmpa_r <= {i_wdata[1:0], buf_r};
    end
  end

  // Shared buffer: one pair access at a time, as software must sequence it
  // high read latches
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_r <= CTR_RST_BYTE;
    end else if (i_wr && i_addr == CTR_OFF_CMPA_LO) begin
      buf_r <= i_wdata;
    end else if (i_rd && i_addr == CTR_OFF_CNT_HI) begin
      buf_r <= cnt_r[7:0];
    end else if (i_rd && i_addr == CTR_OFF_CMPA_HI) begin
      buf_r <= cmpa_r[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid only the cycle after the strobe
  // count byte layout
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= CTR_RST_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        CTR_OFF_CTL_A: rdata_r <= ctl_a_r;
        CTR_OFF_CTL_B: rdata_r <= ctl_b_r;
        CTR_OFF_CNT_LO: rdata_r <= buf_r;
        CTR_OFF_CNT_HI: rdata_r <= {CTR_HI_PAD, cnt_r[9:8]};
        CTR_OFF_CMPA_LO: rdata_r <= buf_r;
        CTR_OFF_CMPA_HI: rdata_r <= {CTR_HI_PAD, cmpa_r[9:8]};
        CTR_OFF_STAT: rdata_r <= {5'h00, stat_r};
        CTR_OFF_MASK: rdata_r <= {5'h00, mask_r};
        default: rdata_r <= CTR_RST_BYTE;
      endcase
    end else begin
      rdata_r <= CTR_RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source: external pin passes two flops before edge detection
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= i_ext_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc_r <= CTR_RST_PRESC;
    end else begin
      presc_r <= presc_r + CTR_PRESC_ONE;
    end
  end

  always_comb begin
    sel_mask = ~(CTR_PRESC_ALL << ctl_a_r.clock_source_select);
    if (ctl_a_r.clock_source_select == CTR_CLK_SEL_EXT) begin
      tick = ext_s2_r & ~ext_s3_r;
    end else begin
      tick = (presc_r & sel_mask) == CTR_RST_PRESC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter core
  // pause gates ticks
  assign run_tick = tick & ctl_a_r.module_on & ~ctl_a_r.pause_ctl;
  assign on_rise = ctl_a_r.module_on & ~on_q_r;
  assign cnt_inc = cnt_r + CTR_CNT_ONE;
  assign cnt_lo_w = cnt_r[7:0];
  assign cnt_hi_w = cnt_r[9:8];
  assign wdata_lo2_w = i_wdata[1:0];
  assign p_hit = run_tick && ctl_a_r.period_select != CTR_PERIOD_FULL &&
                 cnt_inc[9:7] == ctl_a_r.period_select && cnt_inc[6:0] == CTR_P_LOW_ZERO;
  assign a_hit = run_tick && cnt_inc == cmpa_r;
  assign ovf = run_tick && cnt_r == CTR_CNT_MAX;
  assign clr_any = (p_hit && !ctl_b_r.clear_select) || (a_hit && ctl_b_r.clear_select) || ovf;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      on_q_r <= 1'b0;
    end else begin
      on_q_r <= ctl_a_r.module_on;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= CTR_RST_CNT;
    end else if (on_rise) begin
      cnt_r <= CTR_RST_CNT;
    end else if (run_tick) begin
      cnt_r <= clr_any ? CTR_RST_CNT : cnt_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: status read clears, a new event in that cycle wins
  // event flags
  assign ev = {ovf, a_hit, p_hit};
  always_comb begin
    stat_nxt = stat_r;
    if (i_rd && i_addr == CTR_OFF_STAT) begin
      stat_nxt = CTR_RST_EV;
    end
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_r <= CTR_RST_EV;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin; polarity applied after the level so modes share one path
  // mode decode
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_r <= 1'b0;
    end else begin
      case (ctl_b_r.operating_mode_select)
        CTR_MODE_CMP: begin
          if (on_rise) begin
            lvl_r <= ctl_b_r.output_initial_level;
          end else if (a_hit) begin
            case (ctl_b_r.output_function_select)
              CTR_OFN_LOW: lvl_r <= 1'b0;
              CTR_OFN_HIGH: lvl_r <= 1'b1;
              CTR_OFN_TOGGLE: lvl_r <= ~lvl_r;
              default: lvl_r <= lvl_r;
            endcase
          end
        end
        CTR_MODE_PWM: begin
          case (ctl_b_r.output_function_select)
            CTR_PFN_INACTIVE: lvl_r <= 1'b0;
            CTR_PFN_ACTIVE: lvl_r <= 1'b1;
            CTR_PFN_PWM: lvl_r <= ctl_a_r.module_on && (cnt_r < cmpa_r);
            default: lvl_r <= lvl_r;
          endcase
        end
        default: lvl_r <= lvl_r;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tp_r <= 1'b0;
    end else begin
      tp_r <= lvl_r ^ ctl_b_r.output_polarity;
    end
  end

  assign o_rdata = rdata_r;
  assign o_irq = irq_r;
  assign o_tp = tp_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  property p_cnt_ro;
    (i_wr && i_addr == CTR_OFF_CNT_LO && !run_tick && !on_rise) |=> $stable(cnt_r);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count changed by write");

  property p_cmpa_rb;
    (i_wr && i_addr == CTR_OFF_CMPA_HI) ##1 (!i_wr && !i_rd)
      ##1 (i_rd && i_addr == CTR_OFF_CMPA_HI)
      |=> o_rdata == {CTR_HI_PAD, $past(wdata_lo2_w, 3)};
  endproperty
  a_cmpa_rb: assert property (p_cmpa_rb) else $error("compare high readback wrong");

  property p_cnt_hi;
    (i_rd && i_addr == CTR_OFF_CNT_HI) |=> o_rdata == {CTR_HI_PAD, $past(cnt_hi_w)};
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high byte wrong");

  property p_cmpa_lo;
    (i_wr && i_addr == CTR_OFF_CMPA_LO) ##1 (!i_wr && !i_rd)
      ##1 (i_wr && i_addr == CTR_OFF_CMPA_HI) |=> cmpa_r[7:0] == $past(i_wdata, 3);
  endproperty
  a_cmpa_lo: assert property (p_cmpa_lo) else $error("low byte not applied");

  property p_hi_latch;
    (i_rd && i_addr == CTR_OFF_CNT_HI) ##1 (!i_wr && !i_rd)
      ##1 (i_rd && i_addr == CTR_OFF_CNT_LO) |=> o_rdata == $past(cnt_lo_w, 3);
  endproperty
  a_hi_latch: assert property (p_hi_latch) else $error("low byte not latched");

  property p_pause;
    (ctl_a_r.pause_ctl && !on_rise) |=> $stable(cnt_r);
  endproperty
  a_pause: assert property (p_pause) else $error("count moved while paused");

  property p_off;
    !ctl_a_r.module_on ##1 !ctl_a_r.module_on |-> $stable(cnt_r);
  endproperty
  a_off: assert property (p_off) else $error("count moved while off");

  property p_on_clr;
    on_rise |=> cnt_r == CTR_RST_CNT;
  endproperty
  a_on_clr: assert property (p_on_clr) else $error("switch-on did not clear");

  property p_init_lvl;
    (on_rise && ctl_b_r.operating_mode_select == CTR_MODE_CMP)
      |=> ##1 o_tp == ($past(ctl_b_r.output_initial_level, 2) ^ $past(ctl_b_r.output_polarity));
  endproperty
  a_init_lvl: assert property (p_init_lvl) else $error("initial level not forced");

  property p_period;
    (p_hit && !ctl_b_r.clear_select && !on_rise) |=> cnt_r == CTR_RST_CNT && stat_r[CTR_EV_P];
  endproperty
  a_period: assert property (p_period) else $error("period match did not clear");

  property p_wrap;
    (ovf && !on_rise) |=> cnt_r == CTR_RST_CNT && stat_r[CTR_EV_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow not handled");

  property p_step;
    (run_tick && !clr_any && !on_rise) |=> cnt_r == $past(cnt_inc);
  endproperty
  a_step: assert property (p_step) else $error("count did not step");

  property p_irq;
    (|(ev & mask_r)) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_p_hit: cover property (p_hit && !ctl_b_r.clear_select);
  c_a_hit: cover property (a_hit && ctl_b_r.clear_select);
  c_ovf: cover property (ovf);
  c_irq_clear: cover property (o_irq ##1 (i_rd && i_addr == CTR_OFF_STAT) ##1 !o_irq);

endmodule

//--- tb/tb_ctr_timer.sv
/*
  Self-checking bench for the compact timer: registers, counter, period, pin.
  Assumes ctr_pkg and ctr_timer are compiled first; one 100 MHz clock.
*/
`timescale 1ns/1ps
module tb_ctr_timer;
  import ctr_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ext_clk = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_tp;
  int failures = 0;
  int tests_run = 0;

  ctr_timer dut (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_irq(o_irq),
    .i_ext_clk(i_ext_clk),
    .o_tp(o_tp)
  );

  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input int lo, input int hi,
                     input logic [10:0] got);
    tests_run++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // High byte first so the low byte is a coherent snapshot
  task automatic rcnt(output logic [9:0] c);
    logic [7:0] h;
    logic [7:0] l;
    rd(CTR_OFF_CNT_HI, h);
    rd(CTR_OFF_CNT_LO, l);
    chk("count_high_pad", 0, 0, {5'h00, h[7:2]});
    c = {h[1:0], l};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk("reset_value", 0, 0, {3'h0, d});
    end
  endtask

  task automatic t_cmpa();
    logic [7:0] d;
    wr(CTR_OFF_CMPA_LO, 8'hA5);
    wr(CTR_OFF_CMPA_HI, 8'hFF);
    rd(CTR_OFF_CMPA_HI, d);
    chk("cmpa_high", 3, 3, {3'h0, d});
    rd(CTR_OFF_CMPA_LO, d);
    chk("cmpa_low", 8'hA5, 8'hA5, {3'h0, d});
    // Low write alone must land in the buffer only
    wr(CTR_OFF_CMPA_LO, 8'h11);
    rd(CTR_OFF_CMPA_HI, d);
    rd(CTR_OFF_CMPA_LO, d);
    chk("cmpa_low_kept", 8'hA5, 8'hA5, {3'h0, d});
    wr(CTR_OFF_CMPA_LO, 8'h40);
    wr(CTR_OFF_CMPA_HI, 8'h00);
  endtask

  task automatic t_count();
    logic [9:0] c;
    logic [9:0] c0;
    wr(CTR_OFF_CTL_A, 8'h88);
    cyc(4);
    rcnt(c);
    chk("count_paused_on", 0, 0, {1'b0, c});
    wr(CTR_OFF_CTL_A, 8'h08);
    cyc(50);
    wr(CTR_OFF_CTL_A, 8'h88);
    rcnt(c0);
    chk("count_run", 50, 56, {1'b0, c0});
    wr(CTR_OFF_CNT_LO, 8'hFF);
    wr(CTR_OFF_CNT_HI, 8'hFF);
    cyc(20);
    rcnt(c);
    chk("count_held", int'(c0), int'(c0), {1'b0, c});
    wr(CTR_OFF_CTL_A, 8'h08);
    cyc(20);
    wr(CTR_OFF_CTL_A, 8'h00);
    rcnt(c);
    chk("count_resumed", c0 + 20, c0 + 26, {1'b0, c});
    c0 = c;
    cyc(20);
    rcnt(c);
    chk("count_off", int'(c0), int'(c0), {1'b0, c});
    wr(CTR_OFF_CTL_A, 8'h88);
    cyc(2);
    rcnt(c);
    chk("count_cleared", 0, 0, {1'b0, c});
    wr(CTR_OFF_CTL_A, 8'h00);
  endtask

  task automatic t_period();
    logic [7:0] d;
    int n;
    int e;
    wr(CTR_OFF_MASK, 8'h05);
    for (int p = 0; p < 8; p++) begin
      rd(CTR_OFF_STAT, d);
      wr(CTR_OFF_CTL_A, 8'h08 | p[7:0]);
      n = 0;
      while (o_irq !== 1'b1 && n < 1100) begin
        @(posedge i_core_clk);
        #1;
        n++;
      end
      if (n >= 1100) begin
        failures++;
        summarize();
      end
      e = (p == 0) ? 1024 : 128 * p;
      chk("period_cycles", e - 2, e + 4, n[10:0]);
      wr(CTR_OFF_CTL_A, 8'h00);
      rd(CTR_OFF_STAT, d);
      e = (p == 0) ? 4 : 1;
      chk("period_status", e, e, {3'h0, d & ((p == 0) ? 8'h04 : 8'h05)});
      cyc(2);
      chk("irq_cleared", 0, 0, {10'h000, o_irq});
    end
    // Masked event: status sets but the line stays low
    wr(CTR_OFF_MASK, 8'h00);
    wr(CTR_OFF_CTL_A, 8'h09);
    cyc(300);
    chk("irq_masked", 0, 0, {10'h000, o_irq});
    wr(CTR_OFF_CTL_A, 8'h00);
    rd(CTR_OFF_STAT, d);
    chk("status_set", 1, 1, {10'h000, d[0]});
    rd(CTR_OFF_STAT, d);
    chk("status_read_clears", 0, 0, {3'h0, d});
    // Compare A clears instead, so period never matches
    wr(CTR_OFF_CTL_B, 8'h01);
    wr(CTR_OFF_CTL_A, 8'h09);
    cyc(400);
    wr(CTR_OFF_CTL_A, 8'h00);
    rd(CTR_OFF_STAT, d);
    chk("clear_select_a", 2, 2, {3'h0, d & 8'h03});
    wr(CTR_OFF_CTL_B, 8'h00);
  endtask

  task automatic t_pin();
    logic [8:0] tbl [8] = '{9'h108, 9'h000, 9'h00C, 9'h190, 9'h080, 9'h094, 9'h1C0, 9'h1A0};
    for (int i = 0; i < 8; i++) begin
      wr(CTR_OFF_CTL_A, 8'h00);
      wr(CTR_OFF_CTL_B, tbl[i][7:0]);
      // Paused after switch-on, so no compare event disturbs the pin
      wr(CTR_OFF_CTL_A, 8'h88);
      cyc(4);
      chk("pin_level", int'(tbl[i][8]), int'(tbl[i][8]), {10'h000, o_tp});
    end
    wr(CTR_OFF_CTL_A, 8'h00);
    wr(CTR_OFF_CTL_B, 8'h00);
  endtask

  // Compare A is 64 from t_cmpa; bit9 level before the match, bit8 after
  task automatic t_cmp_out();
    logic [9:0] tbl [4] = '{10'h308, 10'h120, 10'h130, 10'h218};
    for (int i = 0; i < 4; i++) begin
      wr(CTR_OFF_CTL_A, 8'h00);
      wr(CTR_OFF_CTL_B, tbl[i][7:0]);
      wr(CTR_OFF_CTL_A, 8'h08);
      cyc(20);
      chk("pin_before_match", int'(tbl[i][9]), int'(tbl[i][9]), {10'h000, o_tp});
      cyc(60);
      chk("pin_after_match", int'(tbl[i][8]), int'(tbl[i][8]), {10'h000, o_tp});
    end
    wr(CTR_OFF_CTL_A, 8'h00);
    wr(CTR_OFF_CTL_B, 8'h00);
  endtask

  task automatic t_clk();
    logic [9:0] c;
    wr(CTR_OFF_CTL_A, 8'h78);
    repeat (10) begin
      cyc(4);
      i_ext_clk <= 1'b1;
      cyc(4);
      i_ext_clk <= 1'b0;
    end
    cyc(6);
    wr(CTR_OFF_CTL_A, 8'hF8);
    rcnt(c);
    chk("ext_ticks", 10, 10, {1'b0, c});
    wr(CTR_OFF_CTL_A, 8'h00);
    wr(CTR_OFF_CTL_A, 8'h18);
    cyc(100);
    wr(CTR_OFF_CTL_A, 8'h98);
    rcnt(c);
    chk("div2_ticks", 48, 56, {1'b0, c});
    wr(CTR_OFF_CTL_A, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_cmpa();
    t_count();
    t_period();
    t_pin();
    t_cmp_out();
    t_clk();
    summarize();
  end
endmodule
